// ---- rtl/gcg_map.svh ----
// Purpose: Constants for the receiver companion pin control
// Assumes: Included by bare name
// Notes: Times in microseconds, counts derived at 10 MHz
`ifndef GCG_MAP_SVH
`define GCG_MAP_SVH

`define GCG_FUNC_SUPPLY_ENABLE 8'h03
`define GCG_FUNC_DATA_READY 8'h04
`define GCG_FUNC_RTC_SHARE 8'h05

`define GCG_MODE_OFF 1'h0
`define GCG_MODE_ON 1'h1

`define GCG_IO_DATA_READY 8'h10
`define GCG_IO_RTC_SHARE 8'h20
`define GCG_IO_CONFIG_RST 8'h00

`define GCG_SEL_SUPPLY 2'h0
`define GCG_SEL_READY 2'h1
`define GCG_SEL_SYNC 2'h2

`define GCG_CLOCK_MHZ 10
`define GCG_SYNC_PULSE_US 100
`define GCG_SYNC_PULSE_CYCLES (`GCG_SYNC_PULSE_US * `GCG_CLOCK_MHZ)
`define GCG_IDLE_DELAY_US 1000
`define GCG_IDLE_DELAY_CYCLES (`GCG_IDLE_DELAY_US * `GCG_CLOCK_MHZ)

`define GCG_CNT_W 16
`define GCG_SYNC_STAGES 2

`endif

// ---- rtl/gcg_pkg.sv ----
// Purpose: Types for the receiver companion pin control
// Assumes: gcg_map.svh supplies widths
// Notes: Power states are Gray coded along active, wait, idle
`include "gcg_map.svh"

package gcg_pkg;

    typedef enum logic [1:0]
    {
        GCG_ACTIVE = 2'h0,
        GCG_IDLE_WAIT = 2'h1,
        GCG_IDLE = 2'h3
    } gcg_power_e;

    typedef logic [`GCG_CNT_W-1:0] gcg_count_t;

    typedef struct packed
    {
        logic [7:0] supply_func;
        logic [7:0] ready_func;
        logic [7:0] sync_func;
        logic rx_mode;
        logic [7:0] io_config;
        logic psv_en;
        gcg_power_e power;
        gcg_count_t idle_cnt;
        gcg_count_t sync_cnt;
        logic supply_prev;
        logic aid_valid;
        logic supply_out;
        logic supply_oe;
        logic ready_sense;
        logic ready_pulldown;
        logic ready_oe;
        logic sync_out;
        logic sync_oe;
        logic idle;
        logic wake;
        logic aid_save;
        logic aid_restore;
        logic host_only;
    } gcg_state_s;

endpackage : gcg_pkg

// ---- rtl/gcg_sync.sv ----
// Purpose: Multi-stage synchroniser for pin inputs
// Assumes: Input is asynchronous to i_clock
// Notes: Only the last stage is to be read
`timescale 1ns/10ps
`default_nettype none

`include "gcg_map.svh"

module gcg_sync
    import gcg_pkg::*;
#(
    parameter int STAGES = `GCG_SYNC_STAGES
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_async,
    output logic o_sync
);

    logic [STAGES-1:0] chain;

    // Shift chain, first stage feeds only the next
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            chain <= '0;
        else
            chain <= {chain[STAGES-2:0], i_async};
    end

    assign o_sync = chain[STAGES-1];

endmodule : gcg_sync

`default_nettype wire

// ---- rtl/gcg_ctrl.sv ----
// Purpose: Pin control for an attached positioning receiver
// Assumes: Command strobes are one-cycle pulses on i_clock
// Notes: Pin outputs come straight from state flops
`timescale 1ns/10ps
`default_nettype none

`include "gcg_map.svh"

module gcg_ctrl
    import gcg_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = `GCG_IDLE_DELAY_CYCLES,
    parameter int unsigned SYNC_CYCLES = `GCG_SYNC_PULSE_CYCLES,
    parameter int SYNC_STAGES = `GCG_SYNC_STAGES
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,

    // Software commands
    input wire logic i_pin_function_cmd,
    input wire logic [1:0] i_pin_function_sel,
    input wire logic [7:0] i_pin_function_code,
    input wire logic i_receiver_mode_cmd,
    input wire logic i_receiver_mode_value,
    input wire logic i_receiver_io_cmd,
    input wire logic [7:0] i_receiver_io_config,
    input wire logic i_power_saving_cmd,
    input wire logic i_power_saving_value,

    // Aiding and bus status
    input wire logic i_local_aiding_enable,
    input wire logic i_aid_save_done,
    input wire logic i_bus_busy,

    // Receiver data-ready pin
    input wire logic i_data_ready_pin,

    // Pin drives
    output logic o_supply_ctrl_pin_out,
    output logic o_supply_ctrl_pin_oe,
    output logic o_data_ready_pin_sense,
    output logic o_data_ready_pin_oe,
    output logic o_data_ready_pin_pulldown,
    output logic o_clock_sync_pin_out,
    output logic o_clock_sync_pin_oe,

    // Power and aiding events
    output logic o_idle,
    output logic o_wake,
    output logic o_aid_save_req,
    output logic o_aid_restore_req,
    output logic o_bus_host_only,

    // Readback
    output logic [7:0] o_supply_func,
    output logic [7:0] o_ready_func,
    output logic [7:0] o_sync_func,
    output logic o_receiver_mode,
    output logic [7:0] o_receiver_io_config,
    output logic o_power_saving
);

    localparam gcg_count_t IDLE_LAST = gcg_count_t'(IDLE_CYCLES - 1);
    localparam gcg_count_t SYNC_LAST = gcg_count_t'(SYNC_CYCLES - 1);

    gcg_state_s state;
    gcg_state_s next_state;
    logic ready_sync;
    logic supply_on;
    logic sense_on;
    logic share_on;
    logic power_up;
    logic power_down;
    logic wake_req;
    logic leave_req;

    // Receiver mode on and IO configuration matches a code
    function automatic logic io_match(input logic mode, input logic [7:0] cfg,
                                      input logic [7:0] code);
        io_match = (mode == `GCG_MODE_ON) && (cfg == code);
    endfunction : io_match

    // Data-ready line into the clock domain
    gcg_sync #(
        .STAGES(SYNC_STAGES)
    ) u_ready_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async(i_data_ready_pin),
        .o_sync(ready_sync)
    );

    always_comb
    begin
        next_state = state;
        supply_on = (state.supply_func == `GCG_FUNC_SUPPLY_ENABLE) &&
                    (state.rx_mode == `GCG_MODE_ON);
        sense_on = (state.ready_func == `GCG_FUNC_DATA_READY) &&
                   io_match(state.rx_mode, state.io_config, `GCG_IO_DATA_READY);
        share_on = (state.sync_func == `GCG_FUNC_RTC_SHARE) &&
                   io_match(state.rx_mode, state.io_config, `GCG_IO_RTC_SHARE);
        power_up = supply_on && !state.supply_prev;
        power_down = !supply_on && state.supply_prev;
        wake_req = sense_on && ready_sync;
        leave_req = !state.psv_en || i_bus_busy || wake_req;

        // Software commands
        if (i_pin_function_cmd)
        begin
            case (i_pin_function_sel)
                `GCG_SEL_SUPPLY: next_state.supply_func = i_pin_function_code;
                `GCG_SEL_READY: next_state.ready_func = i_pin_function_code;
                `GCG_SEL_SYNC: next_state.sync_func = i_pin_function_code;
                default: next_state.supply_func = state.supply_func;
            endcase
        end
        if (i_receiver_mode_cmd)
            next_state.rx_mode = i_receiver_mode_value;
        if (i_receiver_io_cmd)
            next_state.io_config = i_receiver_io_config;
        if (i_power_saving_cmd)
            next_state.psv_en = i_power_saving_value;

        // Supply pin always driven
        next_state.supply_prev = supply_on;
        next_state.supply_oe = 1'b1;
        next_state.supply_out = supply_on;

        // Data-ready pin: input when sensing, else pulled down
        next_state.ready_sense = sense_on;
        next_state.ready_pulldown = !sense_on;
        next_state.ready_oe = 1'b0;

        // Clock-sync pulse at receiver power-up
        next_state.sync_oe = 1'b1;
        if (!share_on)
        begin
            next_state.sync_cnt = '0;
            next_state.sync_out = 1'b0;
        end
        else if (power_up)
        begin
            next_state.sync_cnt = '0;
            next_state.sync_out = 1'b1;
        end
        else if (state.sync_out)
        begin
            if (state.sync_cnt == SYNC_LAST)
            begin
                next_state.sync_out = 1'b0;
                next_state.sync_cnt = '0;
            end
            else
                next_state.sync_cnt = state.sync_cnt + 1'b1;
        end

        // Local aiding save and restore
        next_state.aid_save = i_local_aiding_enable && power_down;
        next_state.aid_restore = i_local_aiding_enable && power_up &&
                                 state.aid_valid;
        if (i_aid_save_done)
            next_state.aid_valid = 1'b1;
        else if (state.aid_restore)
            next_state.aid_valid = 1'b0;

        // Idle entry and wake
        next_state.wake = 1'b0;
        case (state.power)
            // Awake, start the idle delay once quiet
            GCG_ACTIVE:
            begin
                next_state.idle_cnt = '0;
                if (state.psv_en && !i_bus_busy && !wake_req)
                    next_state.power = GCG_IDLE_WAIT;
            end
            // Counting the idle delay
            GCG_IDLE_WAIT:
            begin
                if (leave_req)
                begin
                    next_state.power = GCG_ACTIVE;
                    next_state.idle_cnt = '0;
                end
                else if (state.idle_cnt == IDLE_LAST)
                begin
                    next_state.power = GCG_IDLE;
                    next_state.idle_cnt = '0;
                end
                else
                    next_state.idle_cnt = state.idle_cnt + 1'b1;
            end
            // Asleep until a wake cause
            GCG_IDLE:
            begin
                if (leave_req)
                begin
                    next_state.power = GCG_ACTIVE;
                    next_state.wake = wake_req;
                end
            end
            default:
            begin
                next_state.power = GCG_ACTIVE;
                next_state.idle_cnt = '0;
            end
        endcase
        next_state.idle = (next_state.power == GCG_IDLE);

        // Two-wire bus target mode is never enabled
        next_state.host_only = 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            // Pin functions
            state.supply_func <= `GCG_FUNC_SUPPLY_ENABLE;
            state.ready_func <= `GCG_FUNC_DATA_READY;
            state.sync_func <= `GCG_FUNC_RTC_SHARE;

            // Receiver settings
            state.rx_mode <= `GCG_MODE_OFF;
            state.io_config <= `GCG_IO_CONFIG_RST;
            state.psv_en <= 1'b0;

            // Power and counters
            state.power <= GCG_ACTIVE;
            state.idle_cnt <= '0;
            state.sync_cnt <= '0;
            state.supply_prev <= 1'b0;
            state.aid_valid <= 1'b0;

            // Pin drives
            state.supply_out <= 1'b0;
            state.supply_oe <= 1'b1;
            state.ready_sense <= 1'b0;
            state.ready_pulldown <= 1'b1;
            state.ready_oe <= 1'b0;
            state.sync_out <= 1'b0;
            state.sync_oe <= 1'b1;

            // Event pulses and flags
            state.idle <= 1'b0;
            state.wake <= 1'b0;
            state.aid_save <= 1'b0;
            state.aid_restore <= 1'b0;
            state.host_only <= 1'b1;
        end
        else
            state <= next_state;
    end

    // Supply pin
    assign o_supply_ctrl_pin_out = state.supply_out;
    assign o_supply_ctrl_pin_oe = state.supply_oe;

    // Data-ready pin
    assign o_data_ready_pin_sense = state.ready_sense;
    assign o_data_ready_pin_oe = state.ready_oe;
    assign o_data_ready_pin_pulldown = state.ready_pulldown;

    // Clock-sync pin
    assign o_clock_sync_pin_out = state.sync_out;
    assign o_clock_sync_pin_oe = state.sync_oe;

    // Power and aiding events
    assign o_idle = state.idle;
    assign o_wake = state.wake;
    assign o_aid_save_req = state.aid_save;
    assign o_aid_restore_req = state.aid_restore;
    assign o_bus_host_only = state.host_only;

    // Readback
    assign o_supply_func = state.supply_func;
    assign o_ready_func = state.ready_func;
    assign o_sync_func = state.sync_func;
    assign o_receiver_mode = state.rx_mode;
    assign o_receiver_io_config = state.io_config;
    assign o_power_saving = state.psv_en;

endmodule : gcg_ctrl

`default_nettype wire

// ---- tb/gcg_rx_model.sv ----
// Purpose: Positioning receiver seen from its pins
// Assumes: Supply pin high powers it
// Notes: Unpowered, its ready line falls to the pull-down
`timescale 1ns/10ps
`default_nettype none
module gcg_rx_model
(
    input wire logic i_clock,
    input wire logic i_supply,
    input wire logic i_sync,
    input wire logic i_have_data,
    output logic o_ready,
    output logic [7:0] o_sync_len
);
    assign o_ready = i_supply && i_have_data;
    always_ff @(posedge i_clock)
    begin
        if (!i_supply)
            o_sync_len <= 8'h00;
        else if (i_sync)
            o_sync_len <= o_sync_len + 8'h01;
    end
endmodule : gcg_rx_model
`default_nettype wire

// ---- tb/gcg_ctrl_checker.sv ----
// Purpose: Port assertions for gcg_ctrl
// Assumes: Bound to every gcg_ctrl
// Notes: Pins lag readback by one edge
`timescale 1ns/10ps
`default_nettype none
module gcg_ctrl_checker
#(
    parameter int unsigned IDLE_CYCLES = 8,
    parameter int unsigned SYNC_CYCLES = 4
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_bus_busy,
    input wire logic i_data_ready_pin,
    input wire logic o_supply_ctrl_pin_out,
    input wire logic o_supply_ctrl_pin_oe,
    input wire logic o_data_ready_pin_sense,
    input wire logic o_data_ready_pin_oe,
    input wire logic o_data_ready_pin_pulldown,
    input wire logic o_clock_sync_pin_out,
    input wire logic o_idle,
    input wire logic o_wake,
    input wire logic o_aid_save_req,
    input wire logic o_aid_restore_req,
    input wire logic [7:0] o_ready_func,
    input wire logic [7:0] o_supply_func,
    input wire logic [7:0] o_sync_func,
    input wire logic o_receiver_mode,
    input wire logic [7:0] o_receiver_io_config,
    input wire logic o_power_saving
);
    int unsigned hi_cnt;
    int unsigned q_cnt;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hi_cnt <= 0;
            q_cnt <= 0;
        end
        else
        begin
            hi_cnt <= o_clock_sync_pin_out ? hi_cnt + 1 : 0;
            q_cnt <= (o_power_saving && !i_bus_busy) ? q_cnt + 1 : 0;
        end
    end
    a_supply_level: assert property (
        o_supply_ctrl_pin_oe && o_supply_ctrl_pin_out ==
        $past(o_supply_func == 8'h03 && o_receiver_mode)) else $error("supply pin");
    a_ready_sense: assert property (
        o_data_ready_pin_sense == $past(o_ready_func == 8'h04 && o_receiver_mode
        && o_receiver_io_config == 8'h10)) else $error("ready sense");
    a_ready_float: assert property (o_data_ready_pin_pulldown ==
        (!o_data_ready_pin_sense && !o_data_ready_pin_oe)) else $error("ready float");
    a_sync_gate: assert property (o_clock_sync_pin_out |-> $past(o_sync_func == 8'h05
        && o_receiver_mode && o_receiver_io_config == 8'h20)) else $error("sync gate");
    a_sync_start: assert property (
        $rose(o_clock_sync_pin_out) |-> $rose(o_supply_ctrl_pin_out)) else $error("sync start");
    a_sync_width: assert property (hi_cnt <= SYNC_CYCLES) else $error("sync width");
    a_idle_entry: assert property (
        $rose(o_idle) |-> q_cnt >= IDLE_CYCLES && !$past(i_bus_busy)) else $error("idle");
    a_wake_exit: assert property (
        o_wake |-> $past(o_idle) && !o_idle && $past(i_data_ready_pin, 3)) else $error("wake");
    a_aid_save: assert property (
        o_aid_save_req |-> $fell(o_supply_ctrl_pin_out)) else $error("aid save");
    a_aid_load: assert property (
        o_aid_restore_req |-> $rose(o_supply_ctrl_pin_out)) else $error("aid restore");
endmodule : gcg_ctrl_checker
bind gcg_ctrl gcg_ctrl_checker #(.IDLE_CYCLES(IDLE_CYCLES), .SYNC_CYCLES(SYNC_CYCLES)) u_chk
(
    .i_clock, .i_reset_n, .i_bus_busy, .i_data_ready_pin, .o_supply_ctrl_pin_out,
    .o_supply_ctrl_pin_oe, .o_data_ready_pin_sense, .o_data_ready_pin_oe,
    .o_data_ready_pin_pulldown, .o_clock_sync_pin_out, .o_idle, .o_wake, .o_aid_save_req,
    .o_aid_restore_req, .o_ready_func, .o_supply_func, .o_sync_func, .o_receiver_mode,
    .o_receiver_io_config, .o_power_saving
);
`default_nettype wire

// ---- tb/test_gcg_ctrl.sv ----
// Purpose: Self-checking bench for gcg_ctrl
// Assumes: Idle and sync counts shortened
// Notes: Modes and IO configs drawn from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module test_gcg_ctrl;
    localparam int IC = 8;
    localparam int SC = 4;
    logic clock, reset_n, fcmd, mcmd, mval, iocmd, pcmd, pval, aid, sdone, busy, have, sv;
    logic [1:0] fsel;
    logic [7:0] fcode, io, iov;
    logic [31:0] r;
    wire logic rdy, s_out, s_oe, sense, r_oe, pd, y_out, y_oe, idle, wake, sreq, rreq, host;
    wire logic mode, psv;
    wire logic [7:0] f0, f1, f2, iocfg, slen;
    wire logic [3:0] ev = {rreq, sreq, wake, idle};
    int n_fail, cmp_count, seed, n;
    always #50 clock = ~clock;
    gcg_ctrl #(.IDLE_CYCLES(IC), .SYNC_CYCLES(SC)) u_gcg_ctrl
    (
        .i_clock(clock), .i_reset_n(reset_n), .i_pin_function_cmd(fcmd),
        .i_pin_function_sel(fsel), .i_pin_function_code(fcode), .i_receiver_mode_cmd(mcmd),
        .i_receiver_mode_value(mval), .i_receiver_io_cmd(iocmd), .i_receiver_io_config(io),
        .i_power_saving_cmd(pcmd), .i_power_saving_value(pval), .i_local_aiding_enable(aid),
        .i_aid_save_done(sdone), .i_bus_busy(busy), .i_data_ready_pin(rdy),
        .o_supply_ctrl_pin_out(s_out), .o_supply_ctrl_pin_oe(s_oe),
        .o_data_ready_pin_sense(sense), .o_data_ready_pin_oe(r_oe),
        .o_data_ready_pin_pulldown(pd), .o_clock_sync_pin_out(y_out),
        .o_clock_sync_pin_oe(y_oe), .o_idle(idle), .o_wake(wake), .o_aid_save_req(sreq),
        .o_aid_restore_req(rreq), .o_bus_host_only(host), .o_supply_func(f0),
        .o_ready_func(f1), .o_sync_func(f2), .o_receiver_mode(mode),
        .o_receiver_io_config(iocfg), .o_power_saving(psv)
    );
    gcg_rx_model u_gcg_rx_model
    (
        .i_clock(clock), .i_supply(s_out), .i_sync(y_out), .i_have_data(have),
        .o_ready(rdy), .o_sync_len(slen)
    );
    function automatic logic [7:0] exp_pins(input logic m, input logic [7:0] iv,
                                            input logic [7:0] rf, input logic [7:0] sf);
        logic s;
        s = rf == 8'h04 && m && iv == 8'h10;
        return {5'h00, s, sf == 8'h03 && m, !s};
    endfunction : exp_pins
    task automatic results();
        $display("compared %0d, failed %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : tick
    task automatic cmd(input logic [3:0] k, input logic [7:0] v, input logic [1:0] s);
        @(posedge clock);
        {fcmd, mcmd, iocmd, pcmd} <= k;
        fsel <= s;
        fcode <= v;
        io <= v;
        mval <= v[0];
        pval <= v[0];
        @(posedge clock);
        {fcmd, mcmd, iocmd, pcmd} <= 4'h0;
    endtask : cmd
    task automatic wait_hi(input int k, input int lim);
        tick(1);
        for (int j = 0; j < lim && ev[k] !== 1'b1; j++)
            tick(1);
        chk($sformatf("event%0d", k), {7'h00, ev[k]}, 8'h01);
        if (ev[k] !== 1'b1)
            results();
    endtask : wait_hi
    initial
    begin
        {clock, reset_n, fcmd, mcmd, mval, iocmd, pcmd, pval, aid, sdone, busy, have} = 12'h000;
        {fsel, fcode, io} = 18'h00000;
        seed = 34646;
        n_fail = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        tick(1);
        chk("supply_func", f0, 8'h03);
        chk("ready_func", f1, 8'h04);
        chk("sync_func", f2, 8'h05);
        chk("pins", {3'h0, r_oe, s_oe, sense, s_out, pd}, 8'h09);
        chk("sync_pin", {5'h00, y_oe, y_out, host}, 8'h05);
        $display("reset test done");
        for (n = 0; n < 16; n++)
        begin
            r = $random(seed);
            iov = r[1:0] == 2'h0 ? 8'h10 : (r[1:0] == 2'h1 ? 8'h20 : r[15:8]);
            cmd(4'h2, iov, 2'h0);
            cmd(4'h4, {7'h00, r[4]}, 2'h0);
            tick(2);
            chk("pins", {5'h00, sense, s_out, pd}, exp_pins(r[4], iov, 8'h04, 8'h03));
            chk("io_config", iocfg, iov);
            chk("mode", {7'h00, mode}, {7'h00, r[4]});
        end
        cmd(4'h8, 8'h07, 2'h1);
        cmd(4'h8, 8'h00, 2'h0);
        cmd(4'h8, 8'h06, 2'h3);
        cmd(4'h2, 8'h10, 2'h0);
        cmd(4'h4, 8'h01, 2'h0);
        tick(2);
        chk("pins", {5'h00, sense, s_out, pd}, exp_pins(1'b1, 8'h10, 8'h07, 8'h00));
        chk("sel3", f2, 8'h05);
        chk("sel3_supply", f0, 8'h00);
        chk("sel3_ready", f1, 8'h07);
        cmd(4'h8, 8'h03, 2'h0);
        cmd(4'h8, 8'h04, 2'h1);
        $display("config test done");
        cmd(4'h4, 8'h00, 2'h0);
        cmd(4'h2, 8'h20, 2'h0);
        @(posedge clock);
        aid <= 1'b1;
        cmd(4'h4, 8'h01, 2'h0);
        tick(SC + 4);
        chk("sync_len", slen, 8'(SC));
        chk("sync_end", {7'h00, y_out}, 8'h00);
        cmd(4'h4, 8'h00, 2'h0);
        wait_hi(2, 4);
        @(posedge clock);
        sdone <= 1'b1;
        @(posedge clock);
        sdone <= 1'b0;
        cmd(4'h4, 8'h01, 2'h0);
        wait_hi(3, 4);
        cmd(4'h4, 8'h00, 2'h0);
        cmd(4'h4, 8'h01, 2'h0);
        sv = 1'b0;
        repeat (4)
        begin
            tick(1);
            sv = sv | rreq;
        end
        chk("no_restore", {7'h00, sv}, 8'h00);
        $display("sync and aiding test done");
        cmd(4'h2, 8'h10, 2'h0);
        cmd(4'h1, 8'h01, 2'h0);
        wait_hi(0, IC + 8);
        @(posedge clock);
        busy <= 1'b1;
        tick(2);
        chk("busy_idle", {7'h00, idle}, 8'h00);
        chk("psv", {7'h00, psv}, 8'h01);
        @(posedge clock);
        busy <= 1'b0;
        wait_hi(0, IC + 8);
        @(posedge clock);
        have <= 1'b1;
        wait_hi(1, 6);
        tick(1);
        chk("after_wake", {6'h00, idle, wake}, 8'h00);
        $display("idle test done");
        results();
    end
endmodule : test_gcg_ctrl
`default_nettype wire
